// ===== inc/sdmr_pkg.sv
package sdmr_pkg;
	localparam logic [7:0] SDMR_ADDR_INFO = 8'h00;
	localparam logic [7:0] SDMR_ADDR_FEAT = 8'h01;
	localparam int SDMR_DAI_BIT = 0;
	localparam int SDMR_ZQ_LO = 3;
	localparam logic [1:0] SDMR_ZQ_NOTRUN = 2'h0;
	localparam logic [1:0] SDMR_ZQ_OPEN = 2'h1;
	localparam logic [1:0] SDMR_ZQ_SHORT = 2'h2;
	localparam logic [1:0] SDMR_ZQ_PASS = 2'h3;
	localparam logic [2:0] SDMR_BL4 = 3'h2;
	localparam logic [2:0] SDMR_BL8 = 3'h3;
	localparam logic [2:0] SDMR_BL16 = 3'h4;
	localparam logic [2:0] SDMR_WR_MIN = 3'h1;
	localparam logic [2:0] SDMR_WR_MAX = 3'h6;
	localparam logic [3:0] SDMR_WR_BASE = 4'h2;
	localparam logic [7:0] SDMR_FEAT_RESET = 8'h22;
	localparam logic [3:0] SDMR_CAL_CYCLES = 4'h8;
endpackage

// ===== rtl/sdmr_regs.sv
`timescale 1ns/100ps
module sdmr_regs
	import sdmr_pkg::*;
#(
	parameter int INIT_CYCLES = 16
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic mrw_valid,
	input wire logic [7:0] mrw_addr,
	input wire logic [7:0] mrw_data,
	input wire logic mrr_valid,
	input wire logic [7:0] mrr_addr,
	input wire logic cal_init_cmd,
	input wire logic zq_tied_supply,
	input wire logic zq_shorted_gnd,
	input wire logic burst_start,
	input wire logic burst_is_write,
	input wire logic burst_ap,
	input wire logic [3:0] burst_col,
	output logic [7:0] mrr_data,
	output logic mrr_ack,
	output logic [3:0] beat_col,
	output logic beat_valid,
	output logic burst_illegal,
	output logic precharge_start,
	output logic factory_impedance,
	output logic cal_busy
);
	initial begin
		if (INIT_CYCLES < 1 || INIT_CYCLES > 65535) begin
			$error("INIT_CYCLES out of range");
		end
	end

	typedef enum logic [1:0] {
		SDMR_IDLE = 2'h0, SDMR_BURST = 2'h1, SDMR_REC = 2'h3
	} sdmr_state_e;

	////////////////////////////////////////////////////////////////////////
	// Two-flop synchronisers for pin levels
	logic [1:0] tie_sync_reg, tie_sync_next;
	logic [1:0] gnd_sync_reg, gnd_sync_next;
	always_comb begin
		tie_sync_next = {tie_sync_reg[0], zq_tied_supply};
		gnd_sync_next = {gnd_sync_reg[0], zq_shorted_gnd};
	end
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			tie_sync_reg <= 2'h0;
			gnd_sync_reg <= 2'h0;
		end else begin
			tie_sync_reg <= tie_sync_next;
			gnd_sync_reg <= gnd_sync_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Auto-init, calibration and register state
	logic [15:0] init_cnt_reg, init_cnt_next;
	logic dai_reg, dai_next;
	logic [1:0] zq_reg, zq_next;
	logic [3:0] cal_cnt_reg, cal_cnt_next;
	logic cal_busy_reg, cal_busy_next;
	logic [7:0] feat_reg, feat_next;
	logic [7:0] rd_reg, rd_next;
	logic ack_reg, ack_next;
	logic fimp_reg, fimp_next;
	logic zq_locked;

	assign zq_locked = (zq_reg == SDMR_ZQ_OPEN) || (zq_reg == SDMR_ZQ_SHORT);

	always_comb begin
		init_cnt_next = init_cnt_reg;
		dai_next = dai_reg;
		zq_next = zq_reg;
		cal_cnt_next = cal_cnt_reg;
		cal_busy_next = cal_busy_reg;
		feat_next = feat_reg;
		rd_next = rd_reg;
		ack_next = 1'b0;
		if (dai_reg) begin
			if (init_cnt_reg == 16'(INIT_CYCLES - 1)) begin
				dai_next = 1'b0;
			end else begin
				init_cnt_next = init_cnt_reg + 16'h1;
			end
		end
		if (cal_init_cmd && !cal_busy_reg && !zq_locked) begin
			cal_busy_next = 1'b1;
			cal_cnt_next = 4'h0;
		end else if (cal_busy_reg) begin
			if (cal_cnt_reg == SDMR_CAL_CYCLES - 4'h1) begin
				cal_busy_next = 1'b0;
				if (tie_sync_reg[1]) begin
					zq_next = SDMR_ZQ_OPEN;
				end else if (gnd_sync_reg[1]) begin
					zq_next = SDMR_ZQ_SHORT;
				end else begin
					zq_next = SDMR_ZQ_PASS;
				end
			end else begin
				cal_cnt_next = cal_cnt_reg + 4'h1;
			end
		end
		if (mrw_valid && mrw_addr == SDMR_ADDR_FEAT) begin
			feat_next = mrw_data;
		end
		if (mrr_valid) begin
			ack_next = 1'b1;
			rd_next = 8'h00;
			if (mrr_addr == SDMR_ADDR_INFO) begin
				rd_next[SDMR_DAI_BIT] = dai_reg;
				rd_next[SDMR_ZQ_LO +: 2] = zq_reg;
			end
		end
		fimp_next = zq_locked;
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			init_cnt_reg <= 16'h0;
			dai_reg <= 1'b1;
			zq_reg <= SDMR_ZQ_NOTRUN;
			cal_cnt_reg <= 4'h0;
			cal_busy_reg <= 1'b0;
			feat_reg <= SDMR_FEAT_RESET;
			rd_reg <= 8'h00;
			ack_reg <= 1'b0;
			fimp_reg <= 1'b0;
		end else begin
			init_cnt_reg <= init_cnt_next;
			dai_reg <= dai_next;
			zq_reg <= zq_next;
			cal_cnt_reg <= cal_cnt_next;
			cal_busy_reg <= cal_busy_next;
			feat_reg <= feat_next;
			rd_reg <= rd_next;
			ack_reg <= ack_next;
			fimp_reg <= fimp_next;
		end
	end

	assign mrr_data = rd_reg;
	assign mrr_ack = ack_reg;
	assign factory_impedance = fimp_reg;
	assign cal_busy = cal_busy_reg;

	////////////////////////////////////////////////////////////////////////
	// Burst address sequencer and write recovery
	logic [2:0] bl_code;
	logic bt_int, nowrap;
	logic [2:0] wr_code;
	assign bl_code = feat_reg[2:0];
	assign bt_int = feat_reg[3];
	assign nowrap = feat_reg[4];
	assign wr_code = feat_reg[7:5];

	function automatic logic [3:0] beat_addr(input logic [3:0] start,
			input logic [3:0] idx, input logic [2:0] bl,
			input logic inter, input logic nw);
		logic [3:0] r;
		r = start + idx;
		if (nw) begin
			beat_addr = r;
		end else if (bl == SDMR_BL4) begin
			beat_addr = {start[3:2], r[1:0]};
		end else if (bl == SDMR_BL8) begin
			if (inter) begin
				beat_addr = {start[3], start[2:0] ^ idx[2:0]};
			end else begin
				beat_addr = {start[3], r[2:0]};
			end
		end else begin
			beat_addr = r;
		end
	endfunction

	function automatic logic [3:0] burst_last(input logic [2:0] bl);
		if (bl == SDMR_BL8) begin
			burst_last = 4'h7;
		end else if (bl == SDMR_BL16) begin
			burst_last = 4'hf;
		end else begin
			burst_last = 4'h3;
		end
	endfunction

	sdmr_state_e st_reg, st_next;
	logic [3:0] start_reg, start_next;
	logic [3:0] idx_reg, idx_next;
	logic [3:0] rec_reg, rec_next;
	logic wap_reg, wap_next;
	logic [3:0] bcol_reg, bcol_next;
	logic bval_reg, bval_next;
	logic bill_reg, bill_next;
	logic pre_reg, pre_next;
	logic [3:0] wr_cycles;
	assign wr_cycles = {1'b0, wr_code} + SDMR_WR_BASE;

	always_comb begin
		st_next = st_reg;
		start_next = start_reg;
		idx_next = idx_reg;
		rec_next = rec_reg;
		wap_next = wap_reg;
		bcol_next = bcol_reg;
		bval_next = 1'b0;
		bill_next = 1'b0;
		pre_next = 1'b0;
		case (st_reg)
			SDMR_IDLE: begin
				if (burst_start) begin
					start_next = {burst_col[3:1], 1'b0};
					idx_next = 4'h0;
					wap_next = burst_is_write && burst_ap;
					st_next = SDMR_BURST;
					bill_next = (nowrap && bl_code != SDMR_BL4) ||
						(bt_int && bl_code == SDMR_BL16) ||
						!(bl_code inside {SDMR_BL4, SDMR_BL8, SDMR_BL16}) ||
						(wr_code < SDMR_WR_MIN) ||
						(wr_code > SDMR_WR_MAX);
				end
			end
			SDMR_BURST: begin
				bval_next = 1'b1;
				bcol_next = beat_addr(start_reg, idx_reg, bl_code, bt_int,
					nowrap);
				idx_next = idx_reg + 4'h1;
				if (idx_reg == burst_last(bl_code)) begin
					rec_next = 4'h1;
					st_next = wap_reg ? SDMR_REC : SDMR_IDLE;
				end
			end
			SDMR_REC: begin
				rec_next = rec_reg + 4'h1;
				if (rec_reg == wr_cycles) begin
					pre_next = 1'b1;
					st_next = SDMR_IDLE;
				end
			end
			default: st_next = SDMR_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			st_reg <= SDMR_IDLE;
			start_reg <= 4'h0;
			idx_reg <= 4'h0;
			rec_reg <= 4'h0;
			wap_reg <= 1'b0;
			bcol_reg <= 4'h0;
			bval_reg <= 1'b0;
			bill_reg <= 1'b0;
			pre_reg <= 1'b0;
		end else begin
			st_reg <= st_next;
			start_reg <= start_next;
			idx_reg <= idx_next;
			rec_reg <= rec_next;
			wap_reg <= wap_next;
			bcol_reg <= bcol_next;
			bval_reg <= bval_next;
			bill_reg <= bill_next;
			pre_reg <= pre_next;
		end
	end

	assign beat_col = bcol_reg;
	assign beat_valid = bval_reg;
	assign burst_illegal = bill_reg;
	assign precharge_start = pre_reg;

	////////////////////////////////////////////////////////////////////////
	// Checks
	a_col_zero_even: assert property (@(posedge ref_clk) disable iff (rst)
		beat_valid && $past(idx_reg) == 4'h0 |-> beat_col[0] == 1'b0)
		else $error("start column not even");
	a_info_reserved: assert property (@(posedge ref_clk) disable iff (rst)
		mrr_ack && $past(mrr_addr) == SDMR_ADDR_INFO |->
		mrr_data[7:5] == 3'h0 && mrr_data[2:1] == 2'h0)
		else $error("reserved info bits not zero");
	a_zq_hold_steady: assert property (@(posedge ref_clk) disable iff (rst)
		!$past(cal_busy_reg) |-> $stable(zq_reg))
		else $error("self-test field changed without calibration");
	a_zq_lock_ignore: assert property (@(posedge ref_clk) disable iff (rst)
		zq_locked |=> !cal_busy_reg)
		else $error("calibration accepted while locked");
	a_init_done_clear: assert property (@(posedge ref_clk) disable iff (rst)
		!dai_reg |=> !dai_reg)
		else $error("init status rose again");
	a_bl4_wrap_order: assert property (@(posedge ref_clk) disable iff (rst)
		beat_valid && !nowrap && bl_code == SDMR_BL4 |->
		beat_col[3:2] == start_reg[3:2])
		else $error("four-beat wrap left its block");
	a_bl8_wrap_order: assert property (@(posedge ref_clk) disable iff (rst)
		beat_valid && !nowrap && bl_code == SDMR_BL8 |->
		beat_col[3] == start_reg[3])
		else $error("eight-beat wrap left its block");
	a_prech_delay: assert property (@(posedge ref_clk) disable iff (rst)
		st_reg == SDMR_BURST && st_next == SDMR_REC && wr_code == 3'h1 |->
		##4 precharge_start)
		else $error("precharge not at programmed delay");
endmodule

// ===== tb/sdmr_ctl_model.sv
`timescale 1ns/100ps
module sdmr_ctl_model (
	input wire logic ref_clk,
	input wire logic [7:0] mrr_data,
	input wire logic mrr_ack,
	output logic mrw_valid,
	output logic [7:0] mrw_addr,
	output logic [7:0] mrw_data,
	output logic mrr_valid,
	output logic [7:0] mrr_addr,
	output logic cal_init_cmd,
	output logic burst_start,
	output logic burst_is_write,
	output logic burst_ap,
	output logic [3:0] burst_col
);
	initial begin
		{mrw_valid, mrr_valid, cal_init_cmd, burst_start} = 4'h0;
		{mrw_addr, mrw_data, mrr_addr} = 24'h0;
		{burst_is_write, burst_ap, burst_col} = 6'h0;
	end
	task automatic step();
		@(posedge ref_clk);
		#1;
	endtask
	// Released address, data and column lines show the inverse of their last value
	task automatic mode_register_write_command(input logic [7:0] a, input logic [7:0] d);
		step();
		mrw_valid = 1'b1;
		mrw_addr = a;
		mrw_data = d;
		step();
		mrw_valid = 1'b0;
		mrw_addr = ~a;
		mrw_data = ~d;
	endtask
	task automatic mode_register_read_command(input logic [7:0] a, output logic [7:0] d);
		step();
		mrr_valid = 1'b1;
		mrr_addr = a;
		d = 8'hxx;
		for (int i = 0; i < 8; i++) begin
			@(posedge ref_clk);
			#1;
			if (mrr_ack === 1'b1) begin
				d = mrr_data;
				break;
			end
		end
		mrr_valid = 1'b0;
		mrr_addr = ~a;
	endtask
	task automatic burst(input logic [3:0] c, input logic w, input logic ap);
		step();
		burst_start = 1'b1;
		burst_col = c;
		burst_is_write = w;
		burst_ap = ap;
		step();
		burst_start = 1'b0;
		burst_col = ~c;
	endtask
	task automatic cal();
		step();
		cal_init_cmd = 1'b1;
		step();
		cal_init_cmd = 1'b0;
	endtask
endmodule

// ===== tb/sdmr_mode_regs_burst_order_tb.sv
`timescale 1ns/100ps
module sdram_mode_regs_burst_order_tb
	import sdmr_pkg::*;
;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic zq_tied_supply = 1'b0;
	logic zq_shorted_gnd = 1'b0;
	logic mrw_valid, mrr_valid, cal_init_cmd, burst_start;
	logic burst_is_write, burst_ap, mrr_ack, beat_valid;
	logic burst_illegal, precharge_start, factory_impedance, cal_busy;
	logic [7:0] mrw_addr, mrw_data, mrr_addr, mrr_data, d;
	logic [3:0] burst_col, beat_col;
	int failures = 0;
	int samples_checked = 0;
	int g1, g6;
	sdmr_ctl_model ctl (.*);
	sdmr_regs #(.INIT_CYCLES(4)) uut (
		.ref_clk(ref_clk),
		.rst(rst),
		.mrw_valid(mrw_valid),
		.mrw_addr(mrw_addr),
		.mrw_data(mrw_data),
		.mrr_valid(mrr_valid),
		.mrr_addr(mrr_addr),
		.cal_init_cmd(cal_init_cmd),
		.zq_tied_supply(zq_tied_supply),
		.zq_shorted_gnd(zq_shorted_gnd),
		.burst_start(burst_start),
		.burst_is_write(burst_is_write),
		.burst_ap(burst_ap),
		.burst_col(burst_col),
		.mrr_data(mrr_data),
		.mrr_ack(mrr_ack),
		.beat_col(beat_col),
		.beat_valid(beat_valid),
		.burst_illegal(burst_illegal),
		.precharge_start(precharge_start),
		.factory_impedance(factory_impedance),
		.cal_busy(cal_busy)
	);
	initial begin
		forever #4 ref_clk = ~ref_clk;
	end
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic print_verdict();
		$display("checks %0d failures %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////////
	task automatic t_init();
		ctl.mode_register_read_command(SDMR_ADDR_INFO, d);
		check(d, 8'h01);
		for (int i = 0; i < 10 && d[0] !== 1'b0; i++) begin
			ctl.mode_register_read_command(SDMR_ADDR_INFO, d);
		end
		check(d, 8'h00);
		ctl.mode_register_write_command(SDMR_ADDR_INFO, 8'hff);
		ctl.mode_register_read_command(SDMR_ADDR_INFO, d);
		check(d, 8'h00);
		ctl.mode_register_read_command(SDMR_ADDR_FEAT, d);
		check(d, 8'h00);
		ctl.mode_register_read_command(8'h05, d);
		check(d, 8'h00);
	endtask
	task automatic t_order(input logic [2:0] blc, input logic bt,
			input logic nw, input logic [3:0] col);
		int bl, n;
		logic [3:0] s, e, m;
		bl = (blc == SDMR_BL4) ? 4 : (blc == SDMR_BL8) ? 8 : 16;
		s = col & 4'he;
		m = 4'(bl - 1);
		ctl.mode_register_write_command(SDMR_ADDR_FEAT, {3'h1, nw, bt, blc});
		ctl.burst(col, 1'b0, 1'b0);
		n = 0;
		repeat (24) begin
			@(posedge ref_clk);
			#1;
			if (beat_valid === 1'b1) begin
				e = bt ? (s ^ 4'(n)) : (s + 4'(n));
				e = nw ? s + 4'(n) : ((s & ~m) | (e & m));
				check({4'h0, beat_col}, {4'h0, e});
				n++;
			end
		end
		check(8'(n), 8'(bl));
	endtask
	task automatic t_illegal(input logic [7:0] feat);
		logic seen;
		seen = 1'b0;
		ctl.mode_register_write_command(SDMR_ADDR_FEAT, feat);
		ctl.burst(4'h0, 1'b0, 1'b0);
		repeat (24) begin
			@(posedge ref_clk);
			seen = seen | (burst_illegal === 1'b1);
		end
		check({7'h0, seen}, 8'h01);
	endtask
	task automatic t_pre(input logic [2:0] code, output int gap);
		gap = 0;
		ctl.mode_register_write_command(SDMR_ADDR_FEAT, {code, 2'h0, SDMR_BL4});
		ctl.burst(4'h0, 1'b1, 1'b1);
		repeat (40) begin
			@(posedge ref_clk);
			#1;
			if (beat_valid === 1'b1) begin
				gap = 0;
			end else if (precharge_start === 1'b1) begin
				break;
			end
			gap++;
		end
		repeat (4) ctl.step();
	endtask
	task automatic t_cal(input logic cmd, input logic [7:0] exp, input logic f);
		if (cmd) begin
			ctl.cal();
		end
		repeat (12) ctl.step();
		ctl.mode_register_read_command(SDMR_ADDR_INFO, d);
		check(d, exp);
		check({7'h0, factory_impedance}, {7'h0, f});
	endtask
	////////////////////////////////////////////////////////////////////
	initial begin
		repeat (8) @(posedge ref_clk);
		#1;
		rst = 1'b0;
		t_init();
		t_order(SDMR_BL4, 1'b0, 1'b0, 4'h2);
		t_order(SDMR_BL4, 1'b1, 1'b0, 4'h1);
		t_order(SDMR_BL8, 1'b0, 1'b0, 4'h6);
		t_order(SDMR_BL8, 1'b1, 1'b0, 4'h3);
		t_order(SDMR_BL16, 1'b0, 1'b0, 4'ha);
		t_order(SDMR_BL4, 1'b0, 1'b1, 4'h6);
		t_illegal({3'h1, 2'h1, SDMR_BL16});
		t_illegal({3'h1, 2'h2, SDMR_BL8});
		t_illegal({3'h0, 2'h0, SDMR_BL4});
		t_illegal({3'h1, 2'h0, 3'h0});
		t_pre(SDMR_WR_MIN, g1);
		t_pre(SDMR_WR_MAX, g6);
		check(8'(g6 - g1), 8'h05);
		check(8'(g1), 8'h03);
		t_cal(1'b1, 8'h18, 1'b0);
		zq_tied_supply = 1'b1;
		t_cal(1'b0, 8'h18, 1'b0);
		t_cal(1'b1, 8'h08, 1'b1);
		zq_tied_supply = 1'b0;
		zq_shorted_gnd = 1'b1;
		t_cal(1'b1, 8'h08, 1'b1);
		rst = 1'b1;
		repeat (2) ctl.step();
		rst = 1'b0;
		t_cal(1'b1, 8'h10, 1'b1);
		print_verdict();
	end
	initial begin
		#40000;
		failures++;
		print_verdict();
	end
endmodule
